// ---- accel_decimation_filter_chain.sv ----
`timescale 1ns/10ps
`include "accel_defs.svh"

// Overview of operation
// - Sole acceleration input is a one-bit modulator stream at one bit per microsecond.
// - Third-order sinc, cube of sixteen-tap sum over sixteen, decimates by sixteen.
// - All stages from the gain to the held sample pair run once per sixteen modulator bits.
// - Low-pass is a gain times two cascaded second-order sections.
// - Two-bit low-pass select picks one of three coefficient sets.
// - 180 Hz choice: two poles, tabulated gain and section, unity second section.
// - 400 Hz choice: four poles, tabulated gain and both sections.
// - 800 Hz choice: four poles, tabulated gain and both sections.
// - Compensation corrects offset, sensitivity and non-linearity from factory trim.
// - Linear interpolation between consecutive samples at sixteen phases per sample.
// - Each finished sample is held back one sample period before use.
// - A data request returns the interpolated value at the current phase.
// - Result is clipped to the range and reduced to 10, 9 or 8 bits.
// - Truncation: bits 21..12, 21..13 or 21..14; bits 25..22 are clipped.
// - Pulse-code test output runs only while its enable bit is set.
// - Enabled pulse-code output at 4 MHz, density follows the upper nine bits.
module accel_decimation_filter_chain (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire accel_pkg::mod_stream_t i_mod,
  input wire accel_pkg::lowpass_select_t i_lowpass_select,
  input wire accel_pkg::comp_param_t i_comp,
  input wire logic i_data_req,
  input wire accel_pkg::word_width_t i_word_width,
  input wire logic i_pcm_enable,
  output accel_pkg::accel_word_t o_accel,
  output logic o_pcm,
  output logic o_sample_strobe
);
  import accel_pkg::*;

  // Whole-chain state; stb walks one step per stage after each decimation
  typedef struct packed {
    logic [3:0] stb;
    wide_t xg;
    sample_t comp;
    sample_t prev;
    sample_t cur;
    accel_word_t ans;
    logic sstb;
    logic pcm;
    logic [2:0] pdiv;
    logic [8:0] pacc;
  } chain_state_t;

  chain_state_t q;
  chain_state_t d;

  // Coefficients of one section for the chosen low-pass response
  function automatic biquad_coef_t lpf_coef(input lowpass_select_t s, input logic k);
    case (s)
      LPF_400:
        lpf_coef = k ? '{`C400_N21, `C400_N22, `C400_N23, `C400_D22, `C400_D23}
          : '{`C400_N11, `C400_N12, `C400_N13, `C400_D12, `C400_D13};
      LPF_800:
        lpf_coef = k ? '{`C800_N21, `C800_N22, `C800_N23, `C800_D22, `C800_D23}
          : '{`C800_N11, `C800_N12, `C800_N13, `C800_D12, `C800_D13};
      default:
        lpf_coef = k ? '{`ONE_Q24, 28'sd0, 28'sd0, 28'sd0, 28'sd0}
          : '{`C180_N11, `C180_N12, `C180_N11, `C180_D12, `C180_D13};
    endcase
  endfunction

  // Overall gain ahead of the sections keeps their state small
  function automatic logic signed [31:0] lpf_gain(input lowpass_select_t s);
    case (s)
      LPF_400: lpf_gain = `C400_G;
      LPF_800: lpf_gain = `C800_G;
      default: lpf_gain = `C180_G;
    endcase
  endfunction

  // Over-range bits 25..22 collapse onto the signal limits
  function automatic sample_t clip_sig(input sample_t v);
    if (v > `SIG_MAX)
      clip_sig = `SIG_MAX;
    else if (v < `SIG_MIN)
      clip_sig = `SIG_MIN;
    else
      clip_sig = v;
  endfunction

  // Narrower words are truncated, then sign-extended into ten bits
  function automatic logic signed [9:0] scale_word(input sample_t v, input word_width_t w);
    case (w)
      WORD_9: scale_word = {v[`SIG_MSB], v[`SIG_MSB:`W9_LSB]};
      WORD_8: scale_word = {{2{v[`SIG_MSB]}}, v[`SIG_MSB:`W8_LSB]};
      default: scale_word = v[`SIG_MSB:`W10_LSB];
    endcase
  endfunction

  function automatic sample_t sat_dp(input logic signed [49:0] v);
    if (v > `DP_MAX)
      sat_dp = sample_t'(`DP_MAX);
    else if (v < `DP_MIN)
      sat_dp = sample_t'(`DP_MIN);
    else
      sat_dp = v[`DW-1:0];
  endfunction

  logic sinc_vld;
  logic [12:0] sinc_data;
  logic [3:0] phase;

  sinc3_decimator u_sinc (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_mod(i_mod),
    .o_valid(sinc_vld),
    .o_data(sinc_data),
    .o_phase(phase)
  );

  // Sinc word 0..4096 re-centred on zero, full scale at bit 21
  logic signed [14:0] x15;
  sample_t x26;
  logic signed [57:0] gp;
  assign x15 = $signed({2'b00, sinc_data}) - `SINC_MID;
  assign x26 = sample_t'(x15) <<< `XSHIFT;
  assign gp = x26 * lpf_gain(i_lowpass_select);

  // Two cascaded sections, each stepping one cycle after the previous
  wide_t sec_y [0:1];
  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_sec
      biquad_section u_bq (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_en(q.stb[s]),
        .i_x((s == 0) ? q.xg : sec_y[0]),
        .i_coef(lpf_coef(i_lowpass_select, 1'(s))),
        .o_y(sec_y[s])
      );
    end
  endgenerate

  // Compensation: offset, linear gain and a square-law correction
  sample_t lpf26;
  logic signed [26:0] xc;
  logic signed [42:0] lin;
  logic signed [53:0] sq;
  logic signed [48:0] nlt;
  logic signed [49:0] csum;
  assign lpf26 = sec_y[1][`IW-1:`XFRAC];
  assign xc = 27'(lpf26) - 27'(i_comp.offset);
  assign lin = xc * i_comp.gain;
  assign sq = xc * xc;
  assign nlt = $signed(sq[53:`SQ_SHIFT]) * i_comp.nonlin;
  assign csum = 50'(lin >>> `COMP_FRAC) + 50'(nlt >>> `COMP_FRAC);

  // Interpolation between the held pair at the current bit phase
  logic signed [26:0] diff;
  logic signed [31:0] part;
  sample_t interp;
  sample_t clipped;
  logic [8:0] pval;
  logic [9:0] psum;
  assign diff = 27'(q.cur) - 27'(q.prev);
  assign part = diff * $signed({1'b0, phase});
  assign interp = q.prev + sample_t'(part >>> 4);
  assign clipped = clip_sig(interp);
  // Offset binary of the upper nine signal bits sets the pulse density
  assign pval = {~clipped[`SIG_MSB], clipped[`SIG_MSB-1:`W9_LSB]};
  assign psum = 10'(q.pacc) + 10'(pval);

  always_comb
  begin
    d = q;
    d.stb = {q.stb[2:0], sinc_vld};
    d.sstb = q.stb[3];
    if (sinc_vld)
      d.xg = gp[`GSHIFT+`IW-1:`GSHIFT];
    if (q.stb[2])
      d.comp = sat_dp(csum);
    // New sample enters only after the previous one is complete
    if (q.stb[3])
    begin
      d.prev = q.cur;
      d.cur = q.comp;
    end
    d.ans.valid = i_data_req;
    if (i_data_req)
      d.ans.word = scale_word(clipped, i_word_width);
    // Test output stays quiet and unprimed while disabled
    if (!i_pcm_enable)
    begin
      d.pcm = 1'b0;
      d.pdiv = 3'h0;
      d.pacc = 9'h000;
    end
    else if (q.pdiv == 3'(`PCM_DIV - 1))
    begin
      d.pdiv = 3'h0;
      d.pacc = psum[8:0];
      d.pcm = psum[9];
    end
    else
      d.pdiv = q.pdiv + 3'h1;
  end

  // Clock enable freezes the whole chain, reset clears every filter
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      q <= '0;
    else if (i_ce)
      q <= d;
  end

  assign o_accel = q.ans;
  assign o_pcm = q.pcm;
  assign o_sample_strobe = q.sstb;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_req;
    i_ce && i_data_req;
  endsequence

  sequence s_pipe;
    q.stb[0] && i_ce ##1 i_ce [*3];
  endsequence

  a_req_answer: assert property (
    s_req |=> o_accel.valid && o_accel.word == $past(scale_word(clipped, i_word_width)))
    else $error("request not answered with current interpolated word");
  a_pipe_strobe: assert property (
    s_pipe |=> o_sample_strobe)
    else $error("sample strobe not four stages after decimation");
  a_hold_shift: assert property (
    (q.stb[3] && i_ce) |=> q.prev == $past(q.cur) && q.cur == $past(q.comp))
    else $error("held sample pair not advanced");
  a_interp_span: assert property (
    (interp >= q.prev && interp <= q.cur) || (interp <= q.prev && interp >= q.cur))
    else $error("interpolated value outside held pair");
  a_word_narrow: assert property (
    (o_accel.valid && $past(i_word_width) == WORD_8)
      |-> o_accel.word[9] == o_accel.word[7] && o_accel.word[8] == o_accel.word[7])
    else $error("eight-bit word not sign-extended");
  a_clip_range: assert property (
    clipped <= `SIG_MAX && clipped >= `SIG_MIN)
    else $error("clipped value beyond signal range");
  a_pcm_off: assert property (
    (!i_pcm_enable && i_ce) |=> !o_pcm)
    else $error("test output active while disabled");
  a_pcm_tick: assert property (
    ($changed(o_pcm) && $past(i_ce) && $past(i_pcm_enable))
      |-> $past(q.pdiv) == 3'(`PCM_DIV - 1))
    else $error("test output changed off its 4 MHz slot");

  // Pulse shapes and priming; a stuck pulse would repeat a request or sample
  sequence s_idle_req;
    i_ce && !i_data_req;
  endsequence

  sequence s_pcm_off;
    i_ce && !i_pcm_enable;
  endsequence

  a_ans_pulse: assert property (
    s_idle_req |=> !o_accel.valid)
    else $error("answer valid without a request");
  a_strobe_pulse: assert property (
    (o_sample_strobe && i_ce) |=> !o_sample_strobe)
    else $error("sample strobe longer than one cycle");
  a_gain_load: assert property (
    (sinc_vld && i_ce) |=> q.stb[0])
    else $error("decimated word not taken into the gain stage");
  a_pcm_prime: assert property (
    s_pcm_off |=> q.pdiv == 3'h0 && q.pacc == 9'h000)
    else $error("test output accumulator not cleared while disabled");
  a_pcm_hold: assert property (
    (i_ce && i_pcm_enable && q.pdiv != 3'(`PCM_DIV - 1)) |=> $stable(o_pcm))
    else $error("test output moved between its slots");
  a_word_nine: assert property (
    (o_accel.valid && $past(i_word_width) == WORD_9) |-> o_accel.word[9] == o_accel.word[8])
    else $error("nine-bit word not sign-extended");
  a_word_ten: assert property (
    (o_accel.valid && $past(i_word_width) == WORD_10 && $past(i_ce))
      |-> o_accel.word == $past(clipped[`SIG_MSB:`W10_LSB]))
    else $error("ten-bit word not taken from bits 21 to 12");
endmodule

// ---- accel_defs.svh ----
`ifndef ACCEL_DEFS_SVH
`define ACCEL_DEFS_SVH

// Clocking and rates
`define CLK_HZ 20000000
`define PCM_HZ 4000000
`define PCM_DIV (`CLK_HZ / `PCM_HZ)
`define DECIM_LAST 4'hF

// Datapath widths and fixed-point positions
`define DW 26
`define IW 36
`define CW 28
`define CFRAC 24
`define GSHIFT 22
`define XFRAC 10
`define XSHIFT 10
`define SINC_MID 15'sd2048
`define COMP_FRAC 14
`define SQ_SHIFT 21

// Output scaling field positions and clip limits
`define SIG_MSB 21
`define W10_LSB 12
`define W9_LSB 13
`define W8_LSB 14
`define SIG_MAX 26'sd2097151
`define SIG_MIN (-26'sd2097152)
`define DP_MAX 50'sd33554431
`define DP_MIN (-50'sd33554432)

// Group delay of each low-pass choice, oscillator periods
`define GD_180 4608
`define GD_400 3392
`define GD_800 1728

// Gains in Q32, section coefficients in Q24
`define ONE_Q24 28'sd16777216
`define C180_G 32'sd2293810
`define C180_N11 28'sd4194304
`define C180_N12 28'sd8388608
`define C180_D12 (-28'sd32880652)
`define C180_D13 28'sd16112396
`define C400_G 32'sd13468968
`define C400_N11 28'sd16768
`define C400_N12 28'sd33537
`define C400_N13 28'sd16767
`define C400_D12 (-28'sd31750084)
`define C400_D13 28'sd15025481
`define C400_N21 28'sd4194384
`define C400_N22 28'sd8388374
`define C400_N23 28'sd4194458
`define C400_D22 (-28'sd32196739)
`define C400_D23 28'sd15486591
`define C800_G 32'sd51127762
`define C800_N11 28'sd64451
`define C800_N12 28'sd128904
`define C800_N13 28'sd64450
`define C800_D12 (-28'sd30031294)
`define C800_D13 28'sd13453796
`define C800_N21 28'sd4194335
`define C800_N22 28'sd8388510
`define C800_N23 28'sd4194371
`define C800_D22 (-28'sd30817220)
`define C800_D23 28'sd14297809

`endif

// ---- accel_pkg.sv ----
`include "accel_defs.svh"

package accel_pkg;
  typedef logic signed [`DW-1:0] sample_t;
  typedef logic signed [`IW-1:0] wide_t;
  typedef logic signed [`CW-1:0] coef_t;

  // One second-order section; a1/a2 are the denominator terms
  typedef struct packed {
    coef_t b0;
    coef_t b1;
    coef_t b2;
    coef_t a1;
    coef_t a2;
  } biquad_coef_t;

  typedef enum logic [1:0] {LPF_180, LPF_400, LPF_800} lowpass_select_t;
  typedef enum logic [1:0] {WORD_10, WORD_9, WORD_8} word_width_t;

  // Factory trim: offset, gain Q2.14, square-law term Q2.14
  typedef struct packed {
    sample_t offset;
    logic signed [15:0] gain;
    logic signed [15:0] nonlin;
  } comp_param_t;

  typedef struct packed {
    logic valid;
    logic data;
  } mod_stream_t;

  typedef struct packed {
    logic valid;
    logic signed [9:0] word;
  } accel_word_t;
endpackage

// ---- sinc3_decimator.sv ----
`timescale 1ns/10ps
`include "accel_defs.svh"

module sinc3_decimator (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire accel_pkg::mod_stream_t i_mod,
  output logic o_valid,
  output logic [12:0] o_data,
  output logic [3:0] o_phase
);
  import accel_pkg::*;

  // Modular 13-bit arithmetic is exact since the output never exceeds 4096
  typedef struct packed {
    logic [3:0] cnt;
    logic [12:0] i1;
    logic [12:0] i2;
    logic [12:0] i3;
    logic [12:0] c1;
    logic [12:0] c2;
    logic [12:0] c3;
    logic [12:0] out;
    logic vld;
  } sinc_state_t;

  sinc_state_t q;
  sinc_state_t d;
  logic [12:0] n1;
  logic [12:0] n2;
  logic [12:0] n3;
  logic [12:0] t1;
  logic [12:0] t2;

  // Integrators at bit rate, combs at the decimated rate
  always_comb
  begin
    d = q;
    d.vld = 1'b0;
    n1 = q.i1 + {12'h000, i_mod.data};
    n2 = q.i2 + n1;
    n3 = q.i3 + n2;
    t1 = n3 - q.c1;
    t2 = t1 - q.c2;
    if (i_mod.valid)
    begin
      d.i1 = n1;
      d.i2 = n2;
      d.i3 = n3;
      d.cnt = q.cnt + 4'h1;
      if (q.cnt == `DECIM_LAST)
      begin
        d.c1 = n3;
        d.c2 = t1;
        d.c3 = t2;
        d.out = t2 - q.c3;
        d.vld = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      q <= '0;
    else if (i_ce)
      q <= d;
  end

  assign o_valid = q.vld;
  assign o_data = q.out;
  assign o_phase = q.cnt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_sinc_decim: assert property (
    (o_valid && $past(i_ce)) |-> $past(i_mod.valid && q.cnt == `DECIM_LAST))
    else $error("decimated word without sixteenth bit");
  a_sinc_range: assert property (
    o_data <= 13'h1000)
    else $error("sinc output above unity");
endmodule

// ---- biquad_section.sv ----
`timescale 1ns/10ps
`include "accel_defs.svh"

module biquad_section (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_en,
  input wire accel_pkg::wide_t i_x,
  input wire accel_pkg::biquad_coef_t i_coef,
  output accel_pkg::wide_t o_y
);
  import accel_pkg::*;

  typedef struct packed {
    wide_t x1;
    wide_t x2;
    wide_t y1;
    wide_t y2;
    wide_t y;
  } bq_state_t;

  bq_state_t q;
  bq_state_t d;
  logic signed [67:0] acc;
  wide_t y_new;

  // Direct form I; the wide accumulator absorbs the section's DC gain
  always_comb
  begin
    d = q;
    acc = i_coef.b0 * i_x + i_coef.b1 * q.x1 + i_coef.b2 * q.x2
      - i_coef.a1 * q.y1 - i_coef.a2 * q.y2;
    y_new = acc[`CFRAC+`IW-1:`CFRAC];
    if (i_en)
    begin
      d.x2 = q.x1;
      d.x1 = i_x;
      d.y2 = q.y1;
      d.y1 = y_new;
      d.y = y_new;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      q <= '0;
    else if (i_ce)
      q <= d;
  end

  assign o_y = q.y;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_iir_step: assert property (
    $changed(o_y) |-> $past(i_en && i_ce) && q.y1 == o_y && q.x1 == $past(i_x))
    else $error("section output moved outside its sample strobe");
endmodule

// ---- mod_source.sv ----
`timescale 1ns/10ps

module mod_source (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ones,
  input wire logic [4:0] i_gap,
  output accel_pkg::mod_stream_t o_mod
);
  import accel_pkg::*;

  logic [4:0] cnt_q;

  // One bit every i_gap+1 clocks; data wanders between bits so nothing leans on it
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_q <= 5'h00;
      o_mod <= '0;
    end
    else if (cnt_q >= i_gap)
    begin
      cnt_q <= 5'h00;
      o_mod.valid <= 1'b1;
      o_mod.data <= i_ones;
    end
    else
    begin
      cnt_q <= cnt_q + 5'h01;
      o_mod.valid <= 1'b0;
      o_mod.data <= ~o_mod.data;
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps

module tb;
  import accel_pkg::*;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b0;
  logic ones = 1'b1;
  logic [4:0] gap = 5'h00;
  mod_stream_t mod;
  lowpass_select_t sel = LPF_180;
  comp_param_t comp = '{26'h0, 16'h4000, 16'h0};
  logic req = 1'b0;
  word_width_t width = WORD_10;
  logic pcm_en = 1'b0;
  accel_word_t accel;
  logic pcm;
  logic strobe;
  int miscompares = 0;
  int checks_done = 0;
  int strobes = 0;
  int pcm_ones = 0;
  int s0;
  logic [9:0] exp_q[$];

  // Free-running bench clock
  always #25 clk = ~clk;

  mod_source i_src (
    .i_clk(clk),
    .i_reset_n(reset_n),
    .i_ones(ones),
    .i_gap(gap),
    .o_mod(mod)
  );

  accel_decimation_filter_chain i_dut (
    .i_clk(clk),
    .i_reset_n(reset_n),
    .i_ce(ce),
    .i_mod(mod),
    .i_lowpass_select(sel),
    .i_comp(comp),
    .i_data_req(req),
    .i_word_width(width),
    .i_pcm_enable(pcm_en),
    .o_accel(accel),
    .o_pcm(pcm),
    .o_sample_strobe(strobe)
  );

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    if (seen !== exp)
      miscompares++;
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Back-to-back requests, one per width code; narrower words are floor shifts
  task automatic ask_all(input logic signed [9:0] v);
    repeat ($urandom_range(15)) @(posedge clk);
    for (int w = 0; w < 4; w++)
    begin
      width <= word_width_t'(w[1:0]);
      req <= 1'b1;
      exp_q.push_back(v >>> ((w == 3) ? 0 : w));
      @(posedge clk);
    end
    req <= 1'b0;
    @(posedge clk);
  endtask

  // Trim change needs a couple of samples to reach the held pair
  task automatic run_case(input logic [15:0] g, input logic [15:0] nl, input logic [25:0] off,
                          input logic signed [9:0] v);
    comp <= '{off, g, nl};
    repeat (80) @(posedge clk);
    ask_all(v);
  endtask

  // Long enough for the slowest low-pass choice to reach its DC level
  task automatic settle(input logic level, input lowpass_select_t s);
    ones <= level;
    sel <= s;
    repeat (11200) @(posedge clk);
  endtask

  // Sampled mid-cycle so registered outputs are settled; answers use the oldest note
  always @(negedge clk)
  begin
    if (strobe === 1'b1)
      strobes++;
    if (pcm === 1'b1)
      pcm_ones++;
    if (accel.valid === 1'b1)
      check(accel.word, (exp_q.size() != 0) ? exp_q.pop_front() : 10'hX);
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(100000 * 50);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h2271));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    ce <= 1'b1;
    repeat (100) @(posedge clk);
    s0 = strobes;
    repeat (1600) @(posedge clk);
    check(10'(strobes - s0), 10'h064);
    gap <= 5'h13;
    repeat (400) @(posedge clk);
    s0 = strobes;
    repeat (6400) @(posedge clk);
    check(10'(strobes - s0), 10'h014);
    // Freeze just after a strobe has dropped, so a frozen high strobe is not counted
    wait (strobe === 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    s0 = strobes;
    repeat (400) @(posedge clk);
    check(10'(strobes - s0), 10'h000);
    ce <= 1'b1;
    gap <= 5'h00;
    $display("test strobe rate done");
    settle(1'b1, LPF_180);
    run_case(16'h4000, 16'h0, 26'h0, 10'h1FF);
    check(10'(pcm_ones), 10'h000);
    pcm_en <= 1'b1;
    s0 = pcm_ones;
    repeat (2560) @(posedge clk);
    check({9'h0, ((pcm_ones - s0) / 5) >= 509}, 10'h001);
    pcm_en <= 1'b0;
    run_case(16'h2000, 16'h0, 26'h800, 10'h0FF);
    $display("test lowpass 180 done");
    settle(1'b1, LPF_400);
    run_case(16'h4000, 16'hF000, 26'h800, 10'h17F);
    $display("test lowpass 400 done");
    settle(1'b1, LPF_800);
    run_case(16'h7FFF, 16'h0, 26'h0, 10'h1FF);
    $display("test lowpass 800 done");
    settle(1'b0, lowpass_select_t'(2'h3));
    run_case(16'h4000, 16'h0, 26'h0, 10'h200);
    pcm_en <= 1'b1;
    s0 = pcm_ones;
    repeat (2560) @(posedge clk);
    check(10'(pcm_ones - s0), 10'h000);
    check(10'(exp_q.size()), 10'h000);
    $display("test negative full scale done");
    test_done();
  end
endmodule
